// ===== logic/ascl_pkg.sv
package ascl_pkg;

	// ==========================================================
	// scheme select codes, bit 3 down to bit 0
	localparam logic [3:0] SCHEME_STD = 4'h2;
	localparam logic [3:0] SCHEME_FAST = 4'hD;

	// ==========================================================
	// timing, printed figures and derived cycle counts
	localparam int CLK_MHZ = 125;
	localparam int POR_FAST_US = 6000;
	localparam int POR_STD_US = 100000;
	localparam int RESTART_US = 80;
	localparam int SCLK_TARGET_MHZ = 30;
	localparam int INIT_OSC_MHZ = 10;
	localparam int POR_FAST_CYC = POR_FAST_US * CLK_MHZ;
	localparam int POR_STD_CYC = POR_STD_US * CLK_MHZ;
	localparam int RESTART_CYC = RESTART_US * CLK_MHZ;
	localparam int SCLK_HALF = CLK_MHZ / (2 * SCLK_TARGET_MHZ);
	localparam int INIT_DIV = CLK_MHZ / INIT_OSC_MHZ;
	localparam int INIT_CYCLES = 3180;

	// ==========================================================
	// flash link
	localparam logic [7:0] READ_CMD = 8'h03;
	localparam int CMD_BITS = 32;
	localparam int FRAME_LEN = 16;

	// ==========================================================
	// register map, byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_IMAGE_BYTES = 8'h04;
	localparam logic [7:0] REG_UPDATE_ADDR = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RAW_COUNT = 8'h10;
	localparam int CTRL_AUTO_RESTART = 0;
	localparam int CTRL_REMOTE_EN = 1;
	localparam int CTRL_COMPRESS_EN = 2;
	localparam int STAT_FAST = 4;
	localparam int STAT_ERROR = 8;
	localparam int STAT_USER = 9;
	localparam int STAT_ERRCNT = 16;
	localparam logic CTRL_AUTO_RESTART_RST = 1'b1;
	localparam logic CTRL_REMOTE_EN_RST = 1'b0;
	localparam logic CTRL_COMPRESS_EN_RST = 1'b0;
	localparam logic [23:0] IMAGE_BYTES_RST = 24'h00_0400;
	localparam logic [23:0] UPDATE_ADDR_RST = 24'h00_0000;

	typedef enum logic [2:0] {
		ST_POR,
		ST_RESET,
		ST_LOAD,
		ST_WAIT_DONE,
		ST_INIT,
		ST_USER,
		ST_ERROR
	} ascl_state_e;

	typedef struct packed {
		logic program_n;
		logic status_n;
		logic done;
		logic data;
		logic [3:0] scheme;
	} ascl_pins_s;

endpackage

// ===== logic/ascl_link_if.sv
`timescale 1ns/10ps
interface ascl_link_if;
	logic run;
	logic [23:0] addr;
	logic data_s;
	logic sclk;
	logic sel_n;
	logic cmd;
	logic [7:0] rx_byte;
	logic rx_valid;

	modport ctrl (output run, output addr, output data_s,
		input sclk, input sel_n, input cmd, input rx_byte, input rx_valid);
	modport eng (input run, input addr, input data_s,
		output sclk, output sel_n, output cmd, output rx_byte, output rx_valid);
endinterface

// ===== logic/ascl_flash_reader.sv
`timescale 1ns/10ps
module ascl_flash_reader import ascl_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_sync_n,
	// link engine side
	ascl_link_if.eng lk
);

	typedef struct packed {
		logic running;
		logic sclk;
		logic sel_n;
		logic cmd;
		logic [1:0] half;
		logic [31:0] sh;
		logic [5:0] rises;
		logic [7:0] rx;
		logic [2:0] rxn;
		logic [7:0] rx_out;
		logic rx_valid;
	} ascl_rd_s;

	ascl_rd_s r_reg;
	ascl_rd_s r_next;

	// ==========================================================
	// serial clock, command shifter and receiver
	always_comb begin
		r_next = r_reg;
		r_next.rx_valid = 1'b0;
		if (!lk.run) begin
			// select high and clock parked low in every stage other than load
			r_next.running = 1'b0;
			r_next.sel_n = 1'b1;
			r_next.sclk = 1'b0;
			r_next.cmd = 1'b0;
		end else if (!r_reg.running) begin
			r_next.running = 1'b1;
			r_next.sel_n = 1'b0;
			r_next.sh = {READ_CMD, lk.addr};
			r_next.cmd = READ_CMD[7];
			r_next.half = 2'h0;
			r_next.rises = 6'h00;
			r_next.rxn = 3'h0;
		end else if (r_reg.half == 2'(SCLK_HALF - 1)) begin
			r_next.half = 2'h0;
			r_next.sclk = ~r_reg.sclk;
			if (!r_reg.sclk) begin
				if (r_reg.rises != 6'(CMD_BITS + 1)) begin
					r_next.rises = r_reg.rises + 6'h01;
				end
			end else begin
				// command bits change only on the falling edge
				if (r_reg.rises < 6'(CMD_BITS)) begin
					r_next.sh = {r_reg.sh[30:0], 1'b0};
					r_next.cmd = r_reg.sh[30];
				end
				// first fall after the address is the flash's launch edge
				if (r_reg.rises == 6'(CMD_BITS + 1)) begin
					r_next.rx = {r_reg.rx[6:0], lk.data_s};
					r_next.rxn = r_reg.rxn + 3'h1;
					if (r_reg.rxn == 3'h7) begin
						r_next.rx_out = {r_reg.rx[6:0], lk.data_s};
						r_next.rx_valid = 1'b1;
					end
				end
			end
		end else begin
			r_next.half = r_reg.half + 2'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			r_reg <= '{sel_n: 1'b1, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign lk.sclk = r_reg.sclk;
	assign lk.sel_n = r_reg.sel_n;
	assign lk.cmd = r_reg.cmd;
	assign lk.rx_byte = r_reg.rx_out;
	assign lk.rx_valid = r_reg.rx_valid;

endmodule

// ===== logic/ascl_loader.sv
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// What this block does
// - scheme select 0010 picks self-driven serial load with standard reset delay.
// - scheme select 1101 picks self-driven serial load with fast reset delay.
// - fast power-on reset delay lies between 3 ms and 9 ms.
// - standard power-on reset delay lies between 50 ms and 200 ms.
// - during power-on reset, hold status and done low, user pins tri-stated.
// - after power-on reset keep user pins tri-stated with weak pull-ups on.
// - stages run in order: reset, load, initialization.
// - stay in reset while program request or status line reads low.
// - after power-on reset release status, then enter loading.
// - device makes the serial clock itself; it paces every transfer.
// - serial clock between 20 and 40 MHz, near 30 MHz typical.
// - device changes select and command on falling serial clock edges.
// - device samples incoming data on falling serial clock edges.
// - link is clock, command out, data in and active-low select.
// - device controls the flash with commands on its command output.
// - dual-purpose pins act as select and command, then become ordinary I/O.
// - read stream, decompress if compressed, write configuration cells.
// - both scheme settings accept compressed streams.
// - both settings support remote update, enabled or disabled by option.
// - configuration starts by driving select low, then command and address.
// - after last bit release done; initialize only once done reads high.
// - after done goes high count 3,180 init clocks, then user mode.
// - frame error drives status low; auto-restart pulses select, releases, retries.
module ascl_loader import ascl_pkg::*; #(
	parameter int POR_FAST_CYCLES = POR_FAST_CYC,
	parameter int POR_STD_CYCLES = POR_STD_CYC,
	parameter int RESTART_CYCLES = RESTART_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// configuration pins
	input wire logic [3:0] scheme_select,
	input wire logic program_n,
	input wire logic status_n_in,
	output logic status_n_out,
	output logic status_n_oe,
	input wire logic done_in,
	output logic done_out,
	output logic done_oe,
	// flash link
	output logic link_sclk,
	output logic select_out_n,
	output logic select_out_oe,
	output logic command_out,
	output logic command_out_oe,
	input wire logic flash_data_in,
	// configuration cell write port
	output logic cfg_wr_valid,
	output logic [7:0] cfg_wr_data,
	// user pin control
	output logic user_io_tristate,
	output logic weak_pullup_en,
	output logic user_mode
);

	typedef struct packed {
		ascl_pins_s s1;
		ascl_pins_s s2;
		ascl_state_e st;
		logic [23:0] cnt;
		logic [3:0] tick;
		logic fast_sel;
		logic auto_restart;
		logic remote_en;
		logic comp_en;
		logic [23:0] image_bytes;
		logic [23:0] update_addr;
		logic [23:0] raw_cnt;
		logic [4:0] fr_cnt;
		logic [7:0] csum;
		logic esc;
		logic [3:0] run_left;
		logic err_flag;
		logic [7:0] err_cnt;
		logic [7:0] out_data;
		logic out_valid;
		logic a_valid;
		logic a_write;
		logic [7:0] a_addr;
		logic [31:0] rdata;
	} ascl_top_s;

	ascl_top_s r_reg;
	ascl_top_s r_next;
	logic rst_s1_reg;
	logic rst_sync_n;
	ascl_link_if lk ();

	// ==========================================================
	// reset release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_sync_n <= rst_s1_reg;
		end
	end

	// ==========================================================
	// flash link engine
	ascl_flash_reader u_reader (
		.clock(clock),
		.rst_sync_n(rst_sync_n),
		.lk(lk)
	);

	assign lk.run = (r_reg.st == ST_LOAD);
	assign lk.addr = r_reg.remote_en ? r_reg.update_addr : 24'h00_0000;
	assign lk.data_s = r_reg.s2.data;

	// ==========================================================
	// next state
	logic scheme_ok;
	logic tick_wrap;
	logic [23:0] por_last;
	logic [23:0] raw_next;
	logic wr;

	always_comb begin
		r_next = r_reg;
		scheme_ok = 1'b0;
		tick_wrap = 1'b0;
		por_last = 24'h00_0000;
		raw_next = 24'h00_0000;
		wr = 1'b0;
		r_next.s1 = {program_n, status_n_in, done_in, flash_data_in, scheme_select};
		r_next.s2 = r_reg.s1;
		r_next.out_valid = 1'b0;

		// init oscillator tick, runs in every state but waiting for done
		tick_wrap = (r_reg.tick == 4'(INIT_DIV - 1));
		r_next.tick = tick_wrap ? 4'h0 : r_reg.tick + 4'h1;

		// register writes land in the data phase
		wr = r_reg.a_valid && r_reg.a_write;
		if (wr) begin
			case (r_reg.a_addr)
				REG_CTRL: begin
					r_next.auto_restart = hwdata[CTRL_AUTO_RESTART];
					r_next.remote_en = hwdata[CTRL_REMOTE_EN];
					r_next.comp_en = hwdata[CTRL_COMPRESS_EN];
				end
				REG_IMAGE_BYTES: begin
					r_next.image_bytes = hwdata[23:0];
				end
				REG_UPDATE_ADDR: begin
					r_next.update_addr = hwdata[23:0];
				end
				REG_STATUS: begin
					if (hwdata[STAT_ERROR]) begin
						r_next.err_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// zero runs of the decompressor, one byte a cycle
		if (r_reg.run_left != 4'h0) begin
			r_next.run_left = r_reg.run_left - 4'h1;
			r_next.out_data = 8'h00;
			r_next.out_valid = 1'b1;
		end

		case (r_reg.st)
			ST_POR: begin
				scheme_ok = (r_reg.s2.scheme == SCHEME_FAST) || (r_reg.s2.scheme == SCHEME_STD);
				r_next.fast_sel = (r_reg.s2.scheme == SCHEME_FAST);
				por_last = r_next.fast_sel ? 24'(POR_FAST_CYCLES - 1) : 24'(POR_STD_CYCLES - 1);
				if (r_reg.cnt < por_last) begin
					r_next.cnt = r_reg.cnt + 24'h00_0001;
				end else if (scheme_ok) begin
					// other scheme codes are not ours: stay parked here
					r_next.st = ST_RESET;
					r_next.cnt = 24'h00_0000;
				end
			end
			ST_RESET: begin
				r_next.raw_cnt = 24'h00_0000;
				r_next.fr_cnt = 5'h00;
				r_next.csum = 8'h00;
				r_next.esc = 1'b0;
				r_next.run_left = 4'h0;
				r_next.cnt = 24'h00_0000;
				if (r_reg.s2.program_n && r_reg.s2.status_n) begin
					r_next.st = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (lk.rx_valid) begin
					raw_next = r_reg.raw_cnt + 24'h00_0001;
					r_next.raw_cnt = raw_next;
					if (r_reg.fr_cnt == 5'(FRAME_LEN)) begin
						// trailing byte of each frame is the xor of its payload
						r_next.fr_cnt = 5'h00;
						r_next.csum = 8'h00;
						if (lk.rx_byte != r_reg.csum) begin
							r_next.st = ST_ERROR;
							r_next.err_flag = 1'b1;
							r_next.err_cnt = r_reg.err_cnt + 8'h01;
							r_next.cnt = 24'h00_0000;
						end
					end else begin
						r_next.fr_cnt = r_reg.fr_cnt + 5'h01;
						r_next.csum = r_reg.csum ^ lk.rx_byte;
						if (!r_reg.comp_en) begin
							r_next.out_data = lk.rx_byte;
							r_next.out_valid = 1'b1;
						end else if (r_reg.esc) begin
							// escape 00 then n: n zero bytes, n of 0 is a literal 00
							r_next.esc = 1'b0;
							if (lk.rx_byte[3:0] == 4'h0) begin
								r_next.out_data = 8'h00;
								r_next.out_valid = 1'b1;
							end else begin
								r_next.run_left = lk.rx_byte[3:0];
							end
						end else if (lk.rx_byte == 8'h00) begin
							r_next.esc = 1'b1;
						end else begin
							r_next.out_data = lk.rx_byte;
							r_next.out_valid = 1'b1;
						end
					end
					if (raw_next == r_reg.image_bytes && r_next.st == ST_LOAD) begin
						r_next.st = ST_WAIT_DONE;
					end
				end
			end
			ST_WAIT_DONE: begin
				r_next.cnt = 24'h00_0000;
				// divider restarts so the init count spans whole periods
				r_next.tick = 4'h0;
				if (r_reg.s2.done) begin
					r_next.st = ST_INIT;
				end
			end
			ST_INIT: begin
				if (tick_wrap) begin
					r_next.cnt = r_reg.cnt + 24'h00_0001;
					if (r_reg.cnt == 24'(INIT_CYCLES - 1)) begin
						r_next.st = ST_USER;
					end
				end
			end
			ST_USER: begin
				r_next.cnt = 24'h00_0000;
			end
			ST_ERROR: begin
				// link stopped here, so select has risen: that is the pulse
				if (r_reg.auto_restart) begin
					r_next.cnt = r_reg.cnt + 24'h00_0001;
					if (r_reg.cnt == 24'(RESTART_CYCLES - 1)) begin
						r_next.st = ST_RESET;
					end
				end
			end
			default: begin
				r_next.st = ST_POR;
			end
		endcase

		// a program request restarts from any stage past power-on
		if (!r_reg.s2.program_n && r_reg.st != ST_POR) begin
			r_next.st = ST_RESET;
		end

		// address phase capture, zero wait states
		r_next.a_valid = hsel && htrans[1] && hready;
		r_next.a_write = hwrite;
		r_next.a_addr = haddr[7:0];
		r_next.rdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
				REG_CTRL: begin
					r_next.rdata[CTRL_AUTO_RESTART] = r_next.auto_restart;
					r_next.rdata[CTRL_REMOTE_EN] = r_next.remote_en;
					r_next.rdata[CTRL_COMPRESS_EN] = r_next.comp_en;
				end
				REG_IMAGE_BYTES: begin
					r_next.rdata[23:0] = r_next.image_bytes;
				end
				REG_UPDATE_ADDR: begin
					r_next.rdata[23:0] = r_next.update_addr;
				end
				REG_STATUS: begin
					r_next.rdata[2:0] = r_reg.st;
					r_next.rdata[STAT_FAST] = r_reg.fast_sel;
					r_next.rdata[STAT_ERROR] = r_next.err_flag;
					r_next.rdata[STAT_USER] = (r_reg.st == ST_USER);
					r_next.rdata[STAT_ERRCNT +: 8] = r_next.err_cnt;
				end
				REG_RAW_COUNT: begin
					r_next.rdata[23:0] = r_reg.raw_cnt;
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			r_reg <= '{
				st: ST_POR,
				auto_restart: CTRL_AUTO_RESTART_RST,
				remote_en: CTRL_REMOTE_EN_RST,
				comp_en: CTRL_COMPRESS_EN_RST,
				image_bytes: IMAGE_BYTES_RST,
				update_addr: UPDATE_ADDR_RST,
				default: '0
			};
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_reg.rdata;

	// open-drain lines only ever pull low
	assign status_n_out = 1'b0;
	assign done_out = 1'b0;
	assign status_n_oe = (r_reg.st == ST_POR) || (r_reg.st == ST_ERROR) ||
		((r_reg.st == ST_RESET) && !r_reg.s2.program_n);
	assign done_oe = (r_reg.st != ST_WAIT_DONE) && (r_reg.st != ST_INIT) &&
		(r_reg.st != ST_USER);

	// dual-purpose pins drive in every stage except power-on reset and user mode
	assign link_sclk = lk.sclk;
	assign select_out_n = lk.sel_n;
	assign command_out = lk.cmd;
	assign select_out_oe = (r_reg.st != ST_POR) && (r_reg.st != ST_USER);
	assign command_out_oe = (r_reg.st != ST_POR) && (r_reg.st != ST_USER);

	assign cfg_wr_valid = r_reg.out_valid;
	assign cfg_wr_data = r_reg.out_data;

	assign user_io_tristate = (r_reg.st != ST_USER);
	assign weak_pullup_en = (r_reg.st != ST_POR) && (r_reg.st != ST_USER);
	assign user_mode = (r_reg.st == ST_USER);

endmodule

// ===== test/ascl_flash_model.sv
`timescale 1ns/10ps
module ascl_flash_model (
	// serial link from the loader
	input wire logic link_sclk,
	input wire logic flash_chip_sel_n,
	input wire logic flash_cmd_in,
	// data back to the loader
	output logic flash_data_out
);
	logic [7:0] mem [128];
	logic [31:0] cmd_word;
	int rises;
	int bits;

	// ==========================================================
	// command capture, count cleared while deselected
	always @(posedge link_sclk or posedge flash_chip_sel_n) begin
		if (flash_chip_sel_n) begin
			rises <= 0;
		end else begin
			if (rises < 32) begin
				cmd_word <= {cmd_word[30:0], flash_cmd_in};
			end
			rises <= rises + 1;
		end
	end

	// ==========================================================
	// data out after the 32 command bits; line at pull-up level otherwise
	always @(negedge link_sclk or posedge flash_chip_sel_n) begin
		if (flash_chip_sel_n) begin
			bits <= 0;
			flash_data_out <= 1'b1;
		end else if (rises >= 32) begin
			flash_data_out <= mem[7'(cmd_word + bits / 8)][3'(7 - bits % 8)];
			bits <= bits + 1;
		end
	end
endmodule

// ===== test/ascl_loader_sva.sv
`timescale 1ns/10ps
module ascl_loader_sva import ascl_pkg::*; #(
	parameter int POR_FAST_CYCLES = 200,
	parameter int POR_STD_CYCLES = 300,
	parameter int RESTART_CYCLES = 50
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// watched ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic program_n,
	input wire logic status_n_oe,
	input wire logic done_oe,
	input wire logic link_sclk,
	input wire logic select_out_n,
	input wire logic command_out,
	input wire logic user_io_tristate,
	input wire logic weak_pullup_en,
	input wire logic user_mode
);
	localparam int INIT_MIN = INIT_CYCLES * INIT_DIV;
	int err_cnt;
	int done_cnt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// helper counters
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_cnt <= 0;
			done_cnt <= 0;
		end else begin
			err_cnt <= (status_n_oe && program_n && weak_pullup_en) ? err_cnt + 1 : 0;
			done_cnt <= done_oe ? 0 : done_cnt + 1;
		end
	end

	// ==========================================================
	// properties
	chk_por_pins: assert property (!weak_pullup_en && !user_mode |-> status_n_oe && done_oe && user_io_tristate)
		else $error("power-on pins wrong");
	chk_user_pins: assert property (user_io_tristate == !user_mode && !(weak_pullup_en && user_mode))
		else $error("user pin control wrong");
	chk_prog_reset: assert property (!program_n [*5] |-> status_n_oe)
		else $error("program request not holding reset");
	chk_sclk_high: assert property ($rose(link_sclk) |-> ##1 (link_sclk || select_out_n) ##1 !link_sclk)
		else $error("serial clock high phase wrong");
	chk_sclk_low: assert property ($fell(link_sclk) |-> ##1 !link_sclk ##1 (link_sclk || select_out_n))
		else $error("serial clock low phase wrong");
	chk_cmd_edge: assert property ($changed(command_out) && !select_out_n && !$past(select_out_n) |-> $fell(link_sclk))
		else $error("command bit moved off a falling edge");
	chk_sel_edge: assert property ($changed(select_out_n) |-> !link_sclk)
		else $error("select moved while clock high");
	chk_sclk_park: assert property (select_out_n |-> !link_sclk)
		else $error("serial clock running while deselected");
	chk_restart_bound: assert property (err_cnt <= RESTART_CYCLES + 8)
		else $error("status held low too long after error");
	chk_error_done: assert property (status_n_oe && program_n && weak_pullup_en |-> done_oe)
		else $error("done released during error");
	chk_init_count: assert property ($rose(user_mode) |-> done_cnt >= INIT_MIN && done_cnt <= INIT_MIN + 40)
		else $error("initialization length wrong");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus response not okay");
endmodule

bind ascl_loader ascl_loader_sva #(
	.POR_FAST_CYCLES(POR_FAST_CYCLES),
	.POR_STD_CYCLES(POR_STD_CYCLES),
	.RESTART_CYCLES(RESTART_CYCLES)
) ascl_loader_sva_i (
	.clock(clock), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp), .program_n(program_n),
	.status_n_oe(status_n_oe), .done_oe(done_oe), .link_sclk(link_sclk), .select_out_n(select_out_n),
	.command_out(command_out), .user_io_tristate(user_io_tristate), .weak_pullup_en(weak_pullup_en),
	.user_mode(user_mode)
);

// ===== test/ascl_loader_bench.sv
`timescale 1ns/10ps
module ascl_loader_bench import ascl_pkg::*; ();
	localparam int P_FAST = 200;
	localparam int P_STD = 300;
	localparam int P_RST = 50;
	localparam int INIT_TICKS = INIT_CYCLES * INIT_DIV;
	logic clock, rst_n, hsel, hwrite, hready, hreadyout, program_n, status_n_oe, done_oe;
	logic link_sclk, select_out_n, select_out_oe, command_out, command_out_oe, flash_data;
	logic cfg_wr_valid, user_io_tristate, weak_pullup_en, user_mode, status_n_out, done_out;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] scheme_select;
	logic [7:0] cfg_wr_data, x0, x1;
	logic [7:0] pl [32];
	logic [7:0] got_q [$];
	logic [7:0] exp_q [$];
	int errors, compares, n, k;
	assign hready = hreadyout;

	ascl_loader #(.POR_FAST_CYCLES(P_FAST), .POR_STD_CYCLES(P_STD), .RESTART_CYCLES(P_RST)) ascl_loader_i (
		.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
		.scheme_select(scheme_select), .program_n(program_n), .status_n_in(!status_n_oe),
		.status_n_out(status_n_out), .status_n_oe(status_n_oe), .done_in(!done_oe),
		.done_out(done_out), .done_oe(done_oe),
		.link_sclk(link_sclk), .select_out_n(select_out_n), .select_out_oe(select_out_oe),
		.command_out(command_out), .command_out_oe(command_out_oe), .flash_data_in(flash_data),
		.cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data), .user_io_tristate(user_io_tristate),
		.weak_pullup_en(weak_pullup_en), .user_mode(user_mode)
	);

	// undriven dual-purpose pins float to their pull-up level
	ascl_flash_model ascl_flash_model_i (
		.link_sclk(link_sclk), .flash_chip_sel_n(select_out_oe ? select_out_n : 1'b1),
		.flash_cmd_in(command_out_oe ? command_out : 1'b1), .flash_data_out(flash_data)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock) if (cfg_wr_valid === 1'b1) got_q.push_back(cfg_wr_data);

	// ==========================================================
	// helpers
	task automatic print_verdict;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return select_out_n;
			1: return status_n_oe;
			2: return done_oe;
			3: return user_mode;
			default: return weak_pullup_en;
		endcase
	endfunction

	// samples on the falling edge, so values are settled
	task automatic wait_sig(input int s, input logic val, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(negedge clock);
			cnt++;
		end while (pick(s) !== val && cnt < lim);
		if (pick(s) !== val) begin
			errors++;
			print_verdict();
		end
	endtask

	// returns at the rising edge where hready is sampled high
	task automatic wait_ready;
		int t;
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (hreadyout !== 1'b1 && t < 50);
		if (hreadyout !== 1'b1) begin
			errors++;
			print_verdict();
		end
	endtask

	// entered just after a rising edge
	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		ahb(a, 1'b0, 32'h0000_0000, r);
		check($sformatf("reg %h", a), e, r & m);
	endtask

	task automatic do_reset(input logic [3:0] sch, input int por, input logic [31:0] stat);
		int c;
		rst_n <= 1'b0;
		scheme_select <= sch;
		program_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (20) @(negedge clock);
		check("por pins", 32'h0000_000E, {status_n_oe, done_oe, user_io_tristate, weak_pullup_en});
		wait_sig(4, 1'b1, 1000, c);
		check("por length", 1, c + 20 >= por && c + 20 <= por + 8);
		check("held in reset", 1, status_n_oe);
		@(posedge clock);
		rdc(32'(REG_STATUS), 32'h0000_0017, stat);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		errors = 0;
		compares = 0;
		hsel <= 1'b0;
		haddr <= 32'h0000_0000;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= 3'b010;
		hwdata <= 32'h0000_0000;
		do_reset(SCHEME_FAST, P_FAST, 32'h0000_0011);
		rdc(32'(REG_CTRL), 32'h0000_0007, 32'h0000_0001);
		rdc(32'(REG_IMAGE_BYTES), 32'h00FF_FFFF, 32'h0000_0400);
		rdc(32'(REG_UPDATE_ADDR), 32'h00FF_FFFF, 32'h0000_0000);
		ahb(32'(REG_RAW_COUNT), 1'b1, 32'h0000_0123, v);
		rdc(32'(REG_RAW_COUNT), 32'h00FF_FFFF, 32'h0000_0000);
		ahb(32'h0000_0014, 1'b1, 32'hFFFF_FFFF, v);
		rdc(32'h0000_0014, 32'hFFFF_FFFF, 32'h0000_0000);
		do_reset(SCHEME_STD, P_STD, 32'h0000_0001);
		ahb(32'(REG_IMAGE_BYTES), 1'b1, 32'h0000_0022, v);
		ahb(32'(REG_UPDATE_ADDR), 1'b1, 32'h0000_0020, v);
		ahb(32'(REG_CTRL), 1'b1, 32'h0000_0007, v);
		check("pull-ups", 32'h0000_0003, {weak_pullup_en, user_io_tristate});
		for (k = 0; k < 128; k++) ascl_flash_model_i.mem[k] = 8'(k) ^ 8'h5A;
		x0 = 8'h00;
		x1 = 8'h00;
		for (k = 0; k < 32; k++) begin
			pl[k] = (k == 1 || k == 4 || k == 5) ? 8'h00 : (k == 2) ? 8'h03 : 8'(8'h40 + k);
			ascl_flash_model_i.mem[32 + k + k / 16] = pl[k];
			if (k < 16) x0 ^= pl[k];
			else x1 ^= pl[k];
		end
		ascl_flash_model_i.mem[48] = x0;
		// second frame checksum spoiled to force a frame error
		ascl_flash_model_i.mem[65] = ~x1;
		k = 0;
		while (k < 32) begin
			if (pl[k] != 8'h00) begin
				exp_q.push_back(pl[k]);
				k++;
			end else begin
				repeat ((pl[k + 1][3:0] == 4'h0) ? 1 : int'(pl[k + 1][3:0])) exp_q.push_back(8'h00);
				k += 2;
			end
		end
		program_n <= 1'b1;
		wait_sig(0, 1'b0, 200, n);
		check("load pins", 32'h0000_0018, {select_out_oe, command_out_oe, status_n_oe, status_n_out, done_out});
		wait_sig(1, 1'b1, 3000, n);
		check("done on error", 1, done_oe);
		ascl_flash_model_i.mem[65] = x1;
		repeat (5) @(negedge clock);
		check("select pulsed", 1, select_out_n);
		wait_sig(1, 1'b0, 200, n);
		check("restart time", 1, n + 5 >= P_RST && n + 5 <= P_RST + 8);
		got_q.delete();
		wait_sig(2, 1'b0, 3000, n);
		repeat (8) @(negedge clock);
		check("byte count", exp_q.size(), got_q.size());
		foreach (exp_q[i]) check("config byte", exp_q[i], got_q[i]);
		check("flash command", 32'h0300_0020, ascl_flash_model_i.cmd_word);
		check("select idle", 1, select_out_n);
		wait_sig(3, 1'b1, 40000, n);
		check("init length", 1, n + 8 >= INIT_TICKS && n + 8 <= INIT_TICKS + 40);
		check("user pins", 32'h0000_0000, {user_io_tristate, weak_pullup_en});
		@(posedge clock);
		rdc(32'(REG_STATUS), 32'h00FF_0307, 32'h0001_0305);
		program_n <= 1'b0;
		repeat (8) @(negedge clock);
		check("reconfig reset", 32'h0000_0003, {status_n_oe, user_io_tristate});
		@(posedge clock);
		ahb(32'(REG_STATUS), 1'b1, 32'h0000_0100, v);
		rdc(32'(REG_STATUS), 32'h0000_0107, 32'h0000_0001);
		print_verdict();
	end
endmodule
